//--- pkg/fepc_pkg.sv
/*
 * Constants, modes and carriers of the front-end power and offset calibration block.
 * Assumes a single 100 MHz clock and no register bus; control bits arrive as ports.
 */
// Overview of operation
// (R1) Chip enable low forces sleep levels everywhere
// (R2) Power state low bit zero means standby
// (R3) Power state 01 is idle, synths on
// (R4) Active, amp enable low: band follows bit
// (R5) Active receive: receive on, band follows bit
// (R6) Active transmit: selected band amplifier turned on
// (R7) Calibration holds front-end sleep high meanwhile
// (R8) Host requests calibration only in receive active
// (R9) Rising request edge starts offset calibration
// (R10) Host waits lock, minimum gain before request
// (R11) Status low within 1 us, high when done
// (R12) Calibration completes within 68 ticks of 44 clocks
// (R13) Result kept while request high, not sleeping
// (R14) Host holds request low 4 us to clear
// (R15) Request low disables calibration correction entirely
// (R16) RF loop multiplier computed from divider words
// (R17) Host keeps RF words within valid ranges
// (R18) RF divider defaults loaded at power-up
// (R19) IF synthesizer defaults to integer mode
// (R20) Host programs IF words for 40 MHz reference
// (R21) Defaults restored when chip enable returns high
// (R22) IF words used only with fractional enable
// (R23) Calibration request synchronised before edge detection
`default_nettype none
package fepc_pkg;
	localparam int          CLK_MHZ        = 100;      // Clock rate
	localparam int          STATUS_LOW_NS  = 1000;     // Longest delay to status low
	localparam int          STATUS_CYC     = (STATUS_LOW_NS * CLK_MHZ) / 1000;
	localparam int          TICK_REF_CYC   = 44;       // Reference periods per tick
	localparam int          CAL_TICKS      = 68;       // Longest calibration in ticks
	localparam int          CAL_CLR_NS     = 4000;     // Least low time to clear
	localparam logic [1:0]  PS_ACTIVE      = 2'h3;     // Power state active
	localparam logic [1:0]  PS_IDLE        = 2'h1;     // Power state idle
	localparam logic        DEF_PRESCALE   = 1'h1;     // RF prescale default
	localparam logic [4:0]  DEF_RF_COARSE  = 5'h0A;    // RF coarse default 10
	localparam logic [2:0]  DEF_RF_SUB     = 3'h0;     // RF subtract default
	localparam logic [6:0]  DEF_RF_NUM     = 7'h30;    // RF numerator default 48
	localparam logic [6:0]  DEF_RF_MOD     = 7'h4F;    // RF modulus default 79
	localparam logic [4:0]  RF_COARSE_OFS  = 5'h03;    // Added to coarse word
	localparam int          RF_COARSE_MUL  = 8;        // Coarse multiplier
	localparam logic [4:0]  IF_INT_COARSE  = 5'h11;    // Integer-mode IF coarse word, arbitrary fixed
	typedef enum logic [2:0] {
		FEPC_SLEEP   = 3'b000,
		FEPC_STANDBY = 3'b001,
		FEPC_IDLE    = 3'b010,
		FEPC_ACTIVE  = 3'b011
	} fepc_mode_e;
	typedef enum logic [1:0] {
		CAL_OFF  = 2'b00,
		CAL_RUN  = 2'b01,
		CAL_HOLD = 2'b10
	} fepc_cal_e;
	// Front-end drive outputs
	typedef struct packed {
		logic ampAOff;
		logic ampBOff;
		logic frontEndSleep;
		logic bandOut;
	} fepc_fe_s;
	// Internal enables
	typedef struct packed {
		logic txOn;
		logic rxOn;
		logic synthOn;
		logic oscOn;
		logic serialOn;
	} fepc_en_s;
	// Synthesizer divider words
	typedef struct packed {
		logic       prescale;
		logic [4:0] coarse;
		logic [2:0] subtract;
		logic [6:0] numerator;
		logic [6:0] modulus;
	} fepc_div_s;
endpackage : fepc_pkg
`default_nettype wire

//--- core/fepc_sync.sv
/*
 * Two-flop synchroniser with a rising-edge pulse decoded combinationally from its registers.
 * Assumes the input is asynchronous to mclk.
 */
`timescale 1ns/1ps
`default_nettype none
module fepc_sync
	import fepc_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic asyncIn,
	output var  logic syncOut,
	output var  logic riseOut
);
	logic meta_r;   // First stage, read only by second
	logic sync_r;   // Second stage
	logic prev_r;   // Delayed copy for edge
	logic meta_nxt;
	logic sync_nxt;
	logic prev_nxt;

	////////////////////////////////////////////////////////////////
	// Next values
	always_comb begin
		meta_nxt = asyncIn;
		sync_nxt = meta_r;
		prev_nxt = sync_r;
	end

	// Registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
			prev_r <= prev_nxt;
		end
	end

	assign syncOut = sync_r;
	assign riseOut = sync_r & ~prev_r;   // R23
endmodule : fepc_sync
`default_nettype wire

//--- core/fepc_top.sv
/*
 * Mode decoder, front-end drive and offset calibration sequencer.
 * Assumes pins are asynchronous, power-state and divider bits come from
 * serial registers held elsewhere, and ticks are reference-clock based.
 */
`timescale 1ns/1ps
`default_nettype none
module fepc_top
	import fepc_pkg::*;
#(
	parameter int TICK_CYC = TICK_REF_CYC  // Clocks per calibration tick
)(
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       chip_enable_pin,
	input  wire logic       direction_select,
	input  wire logic       amp_enable_in,
	input  wire logic       offset_cal_request,
	input  wire logic       power_state_high,
	input  wire logic       power_state_low,
	input  wire logic       bandSelect,
	input  wire logic       if_fractional_on,
	input  wire fepc_div_s  rfWords,
	input  wire fepc_div_s  ifWords,
	output var  fepc_fe_s   feOut,
	output var  fepc_en_s   enOut,
	output var  logic       calStatus,
	output var  logic       calCorrectOn,
	output var  logic       loadDefaults,
	output var  fepc_div_s  rfDivDefaults,
	output var  logic [8:0] rfIntMult,
	output var  fepc_div_s  ifDivUsed
);
	localparam int TICKS_W = $clog2(CAL_TICKS + 1);
	localparam int TCYC_W  = $clog2(TICK_CYC + 1);
	localparam int RUN_MAX = CAL_TICKS * TICK_CYC;       // Longest run in clocks
	localparam int RUN_W   = $clog2(RUN_MAX + 1);

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic ceS, dirS, ampS, calS, calRise, ceRise;
	fepc_sync uCe  (.mclk(mclk), .rst_n(rst_n), .asyncIn(chip_enable_pin),
	                .syncOut(ceS), .riseOut(ceRise));
	fepc_sync uDir (.mclk(mclk), .rst_n(rst_n), .asyncIn(direction_select),
	                .syncOut(dirS), .riseOut());
	fepc_sync uAmp (.mclk(mclk), .rst_n(rst_n), .asyncIn(amp_enable_in),
	                .syncOut(ampS), .riseOut());
	fepc_sync uCal (.mclk(mclk), .rst_n(rst_n), .asyncIn(offset_cal_request),
	                .syncOut(calS), .riseOut(calRise));   // R23

	////////////////////////////////////////////////////////////////
	// Mode decode
	fepc_mode_e mode;
	logic       rxActive;
	always_comb begin
		if (!ceS)                                              // R1
			mode = FEPC_SLEEP;
		else if (!power_state_low)                             // R2
			mode = FEPC_STANDBY;
		else if ({power_state_high, power_state_low} == PS_IDLE) // R3
			mode = FEPC_IDLE;
		else
			mode = FEPC_ACTIVE;
	end
	assign rxActive = (mode == FEPC_ACTIVE) && !dirS && !ampS;

	////////////////////////////////////////////////////////////////
	// Calibration sequencer
	fepc_cal_e          cal_r, cal_nxt;
	logic [TICKS_W-1:0] tick_r, tick_nxt;      // Ticks elapsed
	logic [TCYC_W-1:0]  tcyc_r, tcyc_nxt;      // Clocks within tick
	always_comb begin
		cal_nxt  = cal_r;
		tick_nxt = tick_r;
		tcyc_nxt = tcyc_r;
		case (cal_r)
			CAL_OFF: begin
				if (calRise && rxActive) begin     // R9
					cal_nxt  = CAL_RUN;
					tick_nxt = '0;
					tcyc_nxt = '0;
				end
			end
			CAL_RUN: begin
				if (tcyc_r == TCYC_W'(TICK_CYC - 1)) begin
					tcyc_nxt = '0;
					tick_nxt = tick_r + TICKS_W'(1);
				end else begin
					tcyc_nxt = tcyc_r + TCYC_W'(1);
				end
				if (tick_r == TICKS_W'(CAL_TICKS - 1) &&
				    tcyc_r == TCYC_W'(TICK_CYC - 1))
					cal_nxt = CAL_HOLD;            // R12
			end
			CAL_HOLD: cal_nxt = CAL_HOLD;          // R13
			default:  cal_nxt = CAL_OFF;
		endcase
		if (!calS || !ceS)                         // R13 R15
			cal_nxt = CAL_OFF;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cal_r  <= CAL_OFF;
			tick_r <= '0;
			tcyc_r <= '0;
		end else begin
			cal_r  <= cal_nxt;
			tick_r <= tick_nxt;
			tcyc_r <= tcyc_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Run length counter for the calibration time check
	logic [RUN_W-1:0] runCnt_r, runCnt_nxt;   // Clocks spent in run
	always_comb begin
		if (cal_r == CAL_RUN)
			runCnt_nxt = runCnt_r + RUN_W'(1);
		else
			runCnt_nxt = '0;
	end

	// Counter register, cleared outside a run
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			runCnt_r <= '0;
		else
			runCnt_r <= runCnt_nxt;
	end

	////////////////////////////////////////////////////////////////
	// Front-end outputs and enables, registered
	fepc_fe_s fe_nxt;
	fepc_en_s en_nxt;
	logic     stat_nxt, corr_nxt, ld_nxt;
	always_comb begin
		fe_nxt = '{ampAOff: 1'b1, ampBOff: 1'b1, frontEndSleep: 1'b1, bandOut: 1'b0}; // R1 R2 R3
		en_nxt = '0;
		case (mode)
			FEPC_SLEEP: en_nxt = '0;                                   // R1
			FEPC_STANDBY: begin
				en_nxt.oscOn    = 1'b1;                                 // R2
				en_nxt.serialOn = 1'b1;
			end
			FEPC_IDLE: begin
				en_nxt = '{txOn: 1'b0, rxOn: 1'b0, synthOn: 1'b1,
				           oscOn: 1'b1, serialOn: 1'b1};                // R3
			end
			FEPC_ACTIVE: begin
				en_nxt = '{txOn: 1'b1, rxOn: 1'b1, synthOn: 1'b1,
				           oscOn: 1'b1, serialOn: 1'b1};                // R4
				fe_nxt.frontEndSleep = 1'b0;
				fe_nxt.bandOut       = bandSelect;                      // R4 R5
				if (dirS && ampS) begin
					en_nxt.rxOn = 1'b0;                                  // R6
					fe_nxt.ampAOff = !bandSelect;
					fe_nxt.ampBOff = bandSelect;
				end else if (!dirS && !ampS) begin
					en_nxt.txOn = 1'b0;                                  // R5
				end
				if (cal_nxt == CAL_RUN)
					fe_nxt.frontEndSleep = 1'b1;                        // R7
			end
			default: en_nxt = '0;
		endcase
		stat_nxt = (cal_nxt != CAL_RUN);                                // R11
		corr_nxt = (cal_nxt != CAL_OFF);                                // R15
		ld_nxt   = ceRise;                                              // R21
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			feOut        <= '{ampAOff: 1'b1, ampBOff: 1'b1, frontEndSleep: 1'b1, bandOut: 1'b0};
			enOut        <= '0;
			calStatus    <= 1'b1;
			calCorrectOn <= 1'b0;
			loadDefaults <= 1'b1;   // Power-up load, R18
		end else begin
			feOut        <= fe_nxt;
			enOut        <= en_nxt;
			calStatus    <= stat_nxt;
			calCorrectOn <= corr_nxt;
			loadDefaults <= ld_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	// Divider words
	always_comb begin
		rfDivDefaults = '{prescale: DEF_PRESCALE, coarse: DEF_RF_COARSE,
		                  subtract: DEF_RF_SUB, numerator: DEF_RF_NUM,
		                  modulus: DEF_RF_MOD};                         // R18
		rfIntMult = 9'(RF_COARSE_MUL) * (9'(rfWords.coarse) + 9'(RF_COARSE_OFS))
		            - 9'(rfWords.subtract);                             // R16
		if (if_fractional_on)
			ifDivUsed = ifWords;                                        // R22
		else
			ifDivUsed = '{prescale: 1'b0, coarse: IF_INT_COARSE, subtract: 3'h0,
			              numerator: 7'h00, modulus: 7'h00};            // R19
	end

	////////////////////////////////////////////////////////////////
	// Checks
	property p_sleep;
		@(posedge mclk) disable iff (!rst_n)
		!ceS |=> feOut.frontEndSleep && feOut.ampAOff && feOut.ampBOff && !feOut.bandOut;
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep levels wrong"); // R1

	property p_standby;
		@(posedge mclk) disable iff (!rst_n)
		ceS && !power_state_low |=> enOut.oscOn && !enOut.synthOn && feOut.frontEndSleep;
	endproperty
	a_standby: assert property (p_standby) else $error("standby wrong"); // R2

	property p_idle;
		@(posedge mclk) disable iff (!rst_n)
		mode == FEPC_IDLE |=> enOut.synthOn && !enOut.txOn && !enOut.rxOn;
	endproperty
	a_idle: assert property (p_idle) else $error("idle wrong"); // R3

	property p_band;
		@(posedge mclk) disable iff (!rst_n)
		mode == FEPC_ACTIVE && !ampS |=> feOut.bandOut == $past(bandSelect);
	endproperty
	a_band: assert property (p_band) else $error("band wrong"); // R4

	property p_tx;
		@(posedge mclk) disable iff (!rst_n)
		mode == FEPC_ACTIVE && dirS && ampS |=> feOut.ampAOff != feOut.ampBOff && enOut.txOn;
	endproperty
	a_tx: assert property (p_tx) else $error("tx drive wrong"); // R6

	sequence s_calStart;
		cal_r == CAL_OFF && calRise && rxActive && calS && ceS;
	endsequence
	property p_statusLow;
		@(posedge mclk) disable iff (!rst_n)
		s_calStart |-> ##[1:2] !calStatus && feOut.frontEndSleep;
	endproperty
	a_statusLow: assert property (p_statusLow) else $error("status not low"); // R11

	property p_calEnd;
		@(posedge mclk) disable iff (!rst_n)
		cal_r == CAL_RUN |-> runCnt_r < RUN_W'(RUN_MAX);
	endproperty
	a_calEnd: assert property (p_calEnd) else $error("calibration too long"); // R12

	property p_disable;
		@(posedge mclk) disable iff (!rst_n)
		!calS |=> !calCorrectOn;
	endproperty
	a_disable: assert property (p_disable) else $error("correction left on"); // R15
endmodule : fepc_top
`default_nettype wire

//--- bench/fepc_host_model.sv
/*
 * Host model that raises the calibration request.
 * Assumes mclk at 100 MHz and rst_n active low.
 */
`timescale 1ns/1ps
`default_nettype none
module fepc_host_model
	import fepc_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_n,
	input  wire logic want,
	input  wire logic rxReady,
	output var  logic calReq
);
	localparam int LOW_CYC = (CAL_CLR_NS * CLK_MHZ) / 1000; // Least low time, cycles
	int lowCnt;                               // Cycles spent low
	////////////////////////////////////////////////////////////////
	// Rises only when ready and low long enough
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			calReq <= 1'b0;
			lowCnt <= 0;
		end else begin
			// Low time counts whenever the request is low, wanted or not
			if (calReq)
				lowCnt <= 0;
			else if (lowCnt < LOW_CYC)
				lowCnt <= lowCnt + 1;
			if (!want)
				calReq <= 1'b0;
			else if (rxReady && lowCnt >= LOW_CYC)
				calReq <= 1'b1;
		end
	end
endmodule : fepc_host_model
`default_nettype wire

//--- bench/test_fepc_top.sv
/*
 * Self-checking bench of the mode decoder and calibration.
 * Assumes the host model holds the request spacing.
 */
`timescale 1ns/1ps
`default_nettype none
module test_fepc_top;
	import fepc_pkg::*;
	localparam int TICK = 2; // Short tick
	typedef struct packed {
		logic [5:0] pins;
		fepc_fe_s   fe;
		fepc_en_s   en;
		logic       ckEn;
	} fepc_row_s;
	logic      mclk, rst_n, ce, dir, amp, psh, psl, band;
	logic      fracOn, want, rxReady, calReq;
	fepc_div_s rfW, ifW, rfDivDefaults, ifDivUsed;
	fepc_fe_s  feOut;
	fepc_en_s  enOut;
	logic      calStatus, calCorrectOn, loadDefaults;
	logic [8:0] rfIntMult;
	int        fails, samples_checked, k, cyc;
	fepc_row_s rows [8] = '{
		'{6'h1F, 4'hE, 5'h00, 1'b1}, '{6'h3D, 4'hE, 5'h03, 1'b1},
		'{6'h3B, 4'hE, 5'h07, 1'b1}, '{6'h37, 4'hD, 5'h1F, 1'b1},
		'{6'h27, 4'hD, 5'h0F, 1'b1}, '{6'h26, 4'hC, 5'h0F, 1'b1},
		'{6'h3F, 4'h5, 5'h17, 1'b1}, '{6'h3E, 4'h8, 5'h17, 1'b1}};
	fepc_top #(.TICK_CYC(TICK)) uut (.mclk(mclk), .rst_n(rst_n),
		.chip_enable_pin(ce), .direction_select(dir), .amp_enable_in(amp),
		.offset_cal_request(calReq), .power_state_high(psh),
		.power_state_low(psl), .bandSelect(band), .if_fractional_on(fracOn),
		.rfWords(rfW), .ifWords(ifW), .feOut(feOut), .enOut(enOut),
		.calStatus(calStatus), .calCorrectOn(calCorrectOn),
		.loadDefaults(loadDefaults), .rfDivDefaults(rfDivDefaults),
		.rfIntMult(rfIntMult), .ifDivUsed(ifDivUsed));
	fepc_host_model host (.mclk(mclk), .rst_n(rst_n), .want(want),
		.rxReady(rxReady), .calReq(calReq));
	////////////////////////////////////////////////////////////////
	// Compare one value and count it
	task automatic chk(input string n, input logic [23:0] s, e);
		samples_checked++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			fails++;
		end
	endtask : chk
	// Drive the pin set and let it settle
	task automatic setIn(input logic [5:0] v);
		@(posedge mclk);
		{ce, dir, amp, psh, psl, band} <= v;
		repeat (6) @(posedge mclk);
		#1;
	endtask : setIn
	// Print counts and verdict
	task automatic close_out;
		$display("checked %0d fails %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	////////////////////////////////////////////////////////////////
	// Clock and hang limit
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 8000) begin
			fails++;
			close_out();
		end
	end
	////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{rst_n, ce, dir, amp, psh, psl, band, fracOn, want, rxReady} = '0;
		rfW = '0;
		ifW = '0;
		repeat (6) @(posedge mclk);
		#1;
		chk("rstFe", feOut, 4'hE);
		chk("rstStat", {calStatus, loadDefaults}, 2'h3);
		$display("TEST reset done");
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			setIn(rows[i].pins);
			chk("feOut", feOut, rows[i].fe);
			if (rows[i].ckEn) chk("enOut", enOut, rows[i].en);
		end
		$display("TEST rows done");
		setIn(6'h27);
		{want, rxReady} <= 2'h3;
		k = 0;
		while (calReq !== 1'b1 && k < 600) begin
			@(posedge mclk);
			#1;
			k++;
		end
		k = 0;
		while (calStatus !== 1'b0 && k < 200) begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk("statLow", k <= STATUS_CYC, 1'b1);
		#1;
		chk("calFe", {feOut.frontEndSleep, calCorrectOn}, 2'h3);
		k = 0;
		while (calStatus !== 1'b1 && k < 400) begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk("calTime", k <= CAL_TICKS * TICK, 1'b1);
		repeat (2) @(posedge mclk);
		#1;
		chk("afterFe", feOut, 4'hD);
		chk("held", calCorrectOn, 1'b1);
		want <= 1'b0;
		repeat (6) @(posedge mclk);
		#1;
		chk("calOff", calCorrectOn, 1'b0);
		$display("TEST cal done");
		setIn(6'h23);
		want <= 1'b1;
		repeat (520) @(posedge mclk);
		#1;
		chk("refused", {calStatus, calCorrectOn}, 2'h2);
		want <= 1'b0;
		setIn(6'h27);
		want <= 1'b1;
		repeat (450) @(posedge mclk);
		#1;
		chk("again", calCorrectOn, 1'b1);
		chk("againRun", calStatus, 1'b0);
		setIn(6'h07);
		chk("sleepDrop", calCorrectOn, 1'b0);
		want <= 1'b0;
		@(posedge mclk);
		ce <= 1'b1;
		k = 0;
		while (loadDefaults !== 1'b1 && k < 8) begin
			@(posedge mclk);
			#1;
			k++;
		end
		chk("reload", loadDefaults, 1'b1);
		@(posedge mclk);
		#1;
		chk("reloadPulse", loadDefaults, 1'b0);
		$display("TEST sleep done");
		rfW <= '{1'b1, 5'h1F, 3'h7, 7'h7F, 7'h7F};
		ifW <= '{1'b0, 5'h10, 3'h2, 7'h20, 7'h4F};
		fracOn <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk("multHi", rfIntMult, 9'h109);
		chk("ifFrac", ifDivUsed, ifW);
		chk("rfDef", rfDivDefaults, {DEF_PRESCALE, DEF_RF_COARSE,
			DEF_RF_SUB, DEF_RF_NUM, DEF_RF_MOD});
		rfW <= '{1'b1, 5'h07, 3'h0, 7'h20, 7'h20};
		fracOn <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk("multLo", rfIntMult, 9'h050);
		chk("ifInt", ifDivUsed.coarse, IF_INT_COARSE);
		$display("TEST divider done");
		close_out();
	end
endmodule : test_fepc_top
`default_nettype wire
